// ---- acl_pkg.sv ----
// package: register map, field encodings and carrier types of the ipv4 entry matcher
package acl_pkg;

   // ==========================================================
   // register offsets (byte addresses, one 32-bit word each)
   localparam logic [4:0] OFS_CTRL    = 5'h00;
   localparam logic [4:0] OFS_PROTO   = 5'h04;
   localparam logic [4:0] OFS_SRC_ADR = 5'h08;
   localparam logic [4:0] OFS_SRC_MSK = 5'h0c;
   localparam logic [4:0] OFS_DST_ADR = 5'h10;
   localparam logic [4:0] OFS_DST_MSK = 5'h14;
   localparam logic [4:0] OFS_STATUS  = 5'h18;

   // ==========================================================
   // control register field positions
   localparam int CTL_FTYPE  = 0;   // 2 bits
   localparam int CTL_PROTO  = 4;   // 3 bits
   localparam int CTL_TTL    = 8;   // 2 bits
   localparam int CTL_FRAG   = 10;  // 2 bits
   localparam int CTL_OPT    = 12;  // 2 bits
   localparam int CTL_SRC    = 16;  // 2 bits
   localparam int CTL_DST    = 18;  // 2 bits
   // writable control bits; all others read back as zero
   localparam logic [31:0] CTRL_WMASK = 32'h000f_3f73;

   // ==========================================================
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] ADR_RST  = 32'h0000_0000;
   localparam logic [31:0] MSK_RST  = 32'hffff_ffff;
   localparam logic [7:0]  PROTO_RST = 8'h00;
   localparam logic [15:0] CNT_RST  = 16'h0000;

   // ==========================================================
   // protocol numbers
   localparam logic [7:0] PROTO_ICMP = 8'h01;
   localparam logic [7:0] PROTO_TCP  = 8'h06;
   localparam logic [7:0] PROTO_UDP  = 8'h11;

   // ==========================================================
   // encodings
   typedef enum logic [1:0] {FT_ANY = 2'h0, FT_ETH = 2'h1, FT_ARP = 2'h2, FT_IPV4 = 2'h3}
      frame_type_t;
   typedef enum logic [2:0] {PR_ANY = 3'h0, PR_SPEC = 3'h1, PR_ICMP = 3'h2, PR_UDP = 3'h3,
                             PR_TCP = 3'h4} proto_crit_t;
   // ttl: zero / non-zero ; fragment and options: no / yes
   typedef enum logic [1:0] {TR_ANY = 2'h0, TR_NO = 2'h1, TR_YES = 2'h2} tri_crit_t;
   typedef enum logic [1:0] {AD_ANY = 2'h0, AD_HOST = 2'h1, AD_NET = 2'h2} addr_crit_t;

   // avalon bus states (gray sequence)
   typedef enum logic [1:0] {BS_IDLE = 2'b00, BS_ACK = 2'b01, BS_DONE = 2'b11} bus_st_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic        valid;
      logic [7:0]  proto;
      logic [7:0]  ttl;
      logic        more_frag;
      logic [12:0] frag_ofs;
      logic        options;
      logic [31:0] src_adr;
      logic [31:0] dst_adr;
   } ip_hdr_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } avl_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avl_rsp_t;

endpackage

// ---- ipv4_acl_entry_matcher.sv ----
// ipv4 header matcher of one filter_entry, configured over avalon-mm
//
// Operation
// [R01] ipv4 criteria apply only to ipv4 frame type
// [R02] protocol any ignores protocol number
// [R03] specific protocol equals configured value 0..255
// [R04] icmp mode matches protocol icmp only
// [R05] udp mode matches protocol udp only
// [R06] tcp mode matches protocol tcp only
// [R07] ttl zero refuses frames with ttl above zero
// [R08] ttl non-zero allows frames with ttl above zero
// [R09] fragment no refuses mf or nonzero offset
// [R10] fragment yes allows fragmented frames
// [R11] options no refuses frames with options
// [R12] options yes allows frames with options
// [R13] any makes ttl, fragment, options don't-care
// [R14] source any ignores source address
// [R15] source host needs exact source address
// [R16] source network compares under source mask
// [R17] destination any ignores destination address
// [R18] destination host needs exact destination address
// [R19] destination network compares under destination mask
// [R20] only mask-one bits are compared
// [R21] hit needs all criteria matching together
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ipv4_acl_entry_matcher (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RST,
   // avalon-mm slave
   input  wire acl_pkg::avl_req_t AVL_REQ,
   output logic                  AVL_WAITREQUEST,
   output logic [31:0]           AVL_READDATA,
   // parsed header from the frame parser
   input  wire acl_pkg::ip_hdr_t  HDR,
   // result, one cycle after the header
   output logic                  HIT_VALID,
   output logic                  HIT
);
   import acl_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      bus_st_t     bus;
      logic [31:0] rdata;
      logic        waitreq;
      logic [31:0] ctrl;
      logic [7:0]  proto;
      logic [31:0] src_adr;
      logic [31:0] src_msk;
      logic [31:0] dst_adr;
      logic [31:0] dst_msk;
      logic        hit_valid;
      logic        hit;
      logic [15:0] hit_cnt;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ==========================================================
   // helpers
   function automatic logic adr_match(input addr_crit_t crit, input logic [31:0] frame,
                                      input logic [31:0] cfg, input logic [31:0] msk);
      logic r;
      r = 1'b0;
      case (crit)
         AD_ANY:  r = 1'b1;
         AD_HOST: r = (frame == cfg);
         AD_NET:  r = ((frame & msk) == (cfg & msk));
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic tri_match(input tri_crit_t crit, input logic prop);
      logic r;
      r = 1'b0;
      case (crit)
         TR_ANY:  r = 1'b1;
         TR_NO:   r = !prop;
         TR_YES:  r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ==========================================================
   // match logic
   frame_type_t ftype;
   proto_crit_t pcrit;
   tri_crit_t   ttl_crit;
   tri_crit_t   frag_crit;
   tri_crit_t   opt_crit;
   addr_crit_t  src_crit;
   addr_crit_t  dst_crit;
   logic        proto_ok;
   logic        ttl_ok;
   logic        frag_ok;
   logic        opt_ok;
   logic        src_ok;
   logic        dst_ok;
   logic        all_ok;

   always_comb begin
      ftype     = frame_type_t'(s_q.ctrl[CTL_FTYPE +: 2]);
      pcrit     = proto_crit_t'(s_q.ctrl[CTL_PROTO +: 3]);
      ttl_crit  = tri_crit_t'(s_q.ctrl[CTL_TTL +: 2]);
      frag_crit = tri_crit_t'(s_q.ctrl[CTL_FRAG +: 2]);
      opt_crit  = tri_crit_t'(s_q.ctrl[CTL_OPT +: 2]);
      src_crit  = addr_crit_t'(s_q.ctrl[CTL_SRC +: 2]);
      dst_crit  = addr_crit_t'(s_q.ctrl[CTL_DST +: 2]);
      case (pcrit)
         PR_ANY:  proto_ok = 1'b1;                        // R02
         PR_SPEC: proto_ok = (HDR.proto == s_q.proto);    // R03
         PR_ICMP: proto_ok = (HDR.proto == PROTO_ICMP);   // R04
         PR_UDP:  proto_ok = (HDR.proto == PROTO_UDP);    // R05
         PR_TCP:  proto_ok = (HDR.proto == PROTO_TCP);    // R06
         default: proto_ok = 1'b0;
      endcase
      // "zero" refuses ttl above zero; "non-zero" allows it
      ttl_ok  = tri_match(ttl_crit, HDR.ttl != 8'h00);                          // R07 R08 R13
      frag_ok = tri_match(frag_crit, HDR.more_frag || (HDR.frag_ofs != 13'h0)); // R09 R10 R13
      opt_ok  = tri_match(opt_crit, HDR.options);                               // R11 R12 R13
      src_ok  = adr_match(src_crit, HDR.src_adr, s_q.src_adr, s_q.src_msk);     // R14 R15 R16 R20
      dst_ok  = adr_match(dst_crit, HDR.dst_adr, s_q.dst_adr, s_q.dst_msk);     // R17 R18 R19 R20
      all_ok  = (ftype == FT_IPV4) && proto_ok && ttl_ok && frag_ok && opt_ok   // R01
                && src_ok && dst_ok;                                            // R21
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.hit_valid = HDR.valid;
      s_d.hit       = HDR.valid && all_ok;                // R21
      if (HDR.valid && all_ok) begin
         s_d.hit_cnt = s_q.hit_cnt + 16'h0001;
      end
      case (s_q.bus)
         BS_IDLE: begin
            if (AVL_REQ.read || AVL_REQ.write) begin
               s_d.bus     = BS_ACK;
               s_d.waitreq = 1'b0;
               s_d.rdata   = 32'h0000_0000;
               if (AVL_REQ.read) begin
                  case (AVL_REQ.address)
                     OFS_CTRL:    s_d.rdata = s_q.ctrl;
                     OFS_PROTO:   s_d.rdata = {24'h00_0000, s_q.proto};
                     OFS_SRC_ADR: s_d.rdata = s_q.src_adr;
                     OFS_SRC_MSK: s_d.rdata = s_q.src_msk;
                     OFS_DST_ADR: s_d.rdata = s_q.dst_adr;
                     OFS_DST_MSK: s_d.rdata = s_q.dst_msk;
                     OFS_STATUS:  s_d.rdata = {15'h0000, s_q.hit, s_q.hit_cnt};
                     default:     s_d.rdata = 32'h0000_0000;
                  endcase
               end else begin
                  case (AVL_REQ.address)
                     OFS_CTRL:    s_d.ctrl    = AVL_REQ.writedata & CTRL_WMASK;
                     OFS_PROTO:   s_d.proto   = AVL_REQ.writedata[7:0];
                     OFS_SRC_ADR: s_d.src_adr = AVL_REQ.writedata;
                     OFS_SRC_MSK: s_d.src_msk = AVL_REQ.writedata;
                     OFS_DST_ADR: s_d.dst_adr = AVL_REQ.writedata;
                     OFS_DST_MSK: s_d.dst_msk = AVL_REQ.writedata;
                     OFS_STATUS:  s_d.hit_cnt = CNT_RST;
                     default:     s_d.bus     = BS_ACK;
                  endcase
               end
            end
         end
         BS_ACK: begin
            s_d.bus     = BS_DONE;
            s_d.waitreq = 1'b1;
         end
         BS_DONE: begin
            s_d.bus = BS_IDLE;
         end
         default: begin
            s_d.bus     = BS_IDLE;
            s_d.waitreq = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_q.bus       <= BS_IDLE;
         s_q.rdata     <= 32'h0000_0000;
         s_q.waitreq   <= 1'b1;
         s_q.ctrl      <= CTRL_RST;
         s_q.proto     <= PROTO_RST;
         s_q.src_adr   <= ADR_RST;
         s_q.src_msk   <= MSK_RST;
         s_q.dst_adr   <= ADR_RST;
         s_q.dst_msk   <= MSK_RST;
         s_q.hit_valid <= 1'b0;
         s_q.hit       <= 1'b0;
         s_q.hit_cnt   <= CNT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign AVL_WAITREQUEST = s_q.waitreq;
   assign AVL_READDATA    = s_q.rdata;
   assign HIT_VALID       = s_q.hit_valid;
   assign HIT             = s_q.hit;

endmodule

// ---- acl_entry_checker.sv ----
// checker: bus and match properties of the ipv4 entry matcher
`timescale 1ns/1ps
module acl_entry_checker (
   // clock and reset
   input wire logic              CLK,
   input wire logic              RST,
   // bus
   input wire acl_pkg::avl_req_t AVL_REQ,
   input wire logic              AVL_WAITREQUEST,
   input wire logic [31:0]       AVL_READDATA,
   // header and result
   input wire acl_pkg::ip_hdr_t  HDR,
   input wire logic              HIT_VALID,
   input wire logic              HIT
);
   import acl_pkg::*;
   // =====
   // shadow of control and protocol value
   logic [31:0] ctl_q;
   logic [7:0]  pv_q;
   wire         wr_ok = AVL_REQ.write && !AVL_WAITREQUEST;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctl_q <= '0;
         pv_q  <= '0;
      end else if (wr_ok && AVL_REQ.address == OFS_CTRL) begin
         ctl_q <= AVL_REQ.writedata;
      end else if (wr_ok && AVL_REQ.address == OFS_PROTO) begin
         pv_q <= AVL_REQ.writedata[7:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   AST_ANSWER: assert property ((AVL_REQ.read || AVL_REQ.write) |-> ##[0:4] !AVL_WAITREQUEST)
      else $error("bus request not answered");
   AST_ONE_LOW: assert property (!AVL_WAITREQUEST |=> AVL_WAITREQUEST)
      else $error("waitrequest low too long");
   AST_CAUSE: assert property ($fell(AVL_WAITREQUEST) |-> $past(AVL_REQ.read || AVL_REQ.write))
      else $error("answer without request");
   AST_UNMAPPED: assert property (AVL_REQ.read && AVL_REQ.address > OFS_STATUS
      && !AVL_WAITREQUEST |-> AVL_READDATA == '0) else $error("unmapped read not zero");
   AST_RESULT: assert property (HDR.valid |=> HIT_VALID)
      else $error("no result after header");
   AST_QUIET: assert property (!HDR.valid |=> !HIT_VALID && !HIT)
      else $error("result without header");
   AST_FTYPE: assert property (HDR.valid && ctl_q[1:0] != 2'h3 |=> !HIT)
      else $error("hit with non ipv4 frame type");
   AST_PROTO: assert property (HDR.valid && ctl_q[CTL_PROTO +: 3] == 3'h1
      && HDR.proto != pv_q |=> !HIT) else $error("hit on wrong protocol");
   AST_TTL: assert property (HDR.valid && ctl_q[CTL_TTL +: 2] == 2'h1
      && HDR.ttl != 8'h00 |=> !HIT) else $error("hit with ttl above zero");
   AST_FRAG: assert property (HDR.valid && ctl_q[CTL_FRAG +: 2] == 2'h1
      && (HDR.more_frag || HDR.frag_ofs != '0) |=> !HIT) else $error("hit on fragment");
endmodule

// ---- hdr_parser_model.sv ----
// model of the frame parser that presents ipv4 headers
`timescale 1ns/1ps
module hdr_parser_model (
   // clock
   input wire logic         CLK,
   // header towards the matcher
   output acl_pkg::ip_hdr_t HDR
);
   import acl_pkg::*;
   // idle fields are inverted so stale values never match by chance
   task automatic send(input ip_hdr_t h, input logic last);
      ip_hdr_t n;
      n = ~h;
      n.valid = 1'b0;
      HDR <= h;
      @(posedge CLK);
      if (last) begin
         HDR <= n;
      end
   endtask
   initial begin
      HDR = '0;
   end
endmodule

// ---- tb_ipv4_acl_entry_matcher.sv ----
// testbench of the ipv4 entry matcher
`timescale 1ns/1ps
module tb_ipv4_acl_entry_matcher;
   import acl_pkg::*;
   // =====
   // signals
   localparam logic [31:0] IP = 32'h3;
   logic        CLK = 1'b0;
   logic        RST = 1'b1;
   avl_req_t    req = '0;
   ip_hdr_t     hdr;
   ip_hdr_t     b;
   ip_hdr_t     h;
   logic        wreq;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic        hv;
   logic        hit;
   int          n_fail = 0;
   int          n_compared = 0;
   logic [11:0] pt [9] = '{12'h133, 12'h3ff, 12'h2fe, 12'h501, 12'h406, 12'h711, 12'h606,
                           12'h906, 12'h811};
   initial begin
      forever #4 CLK = ~CLK;
   end
   hdr_parser_model P (.CLK(CLK), .HDR(hdr));
   ipv4_acl_entry_matcher DUT (.CLK(CLK), .RST(RST), .AVL_REQ(req), .AVL_WAITREQUEST(wreq),
      .AVL_READDATA(rdata), .HDR(hdr), .HIT_VALID(hv), .HIT(hit));
   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic r, input logic [4:0] a, input logic [31:0] d);
      req <= '{read: r, write: !r, address: a, writedata: d};
      for (int i = 0; i <= 20; i++) begin
         @(posedge CLK);
         if (wreq === 1'b0) break;
         if (i == 20) begin
            n_fail++;
            report_and_stop();
         end
      end
      rv = rdata;
      req <= '0;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      acc(1'b0, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      acc(1'b1, a, 32'h0);
      chk(rv, e);
   endtask
   // one header against one control setting, result checked a cycle later
   task automatic ev(input logic [31:0] c, input logic e);
      wr(OFS_CTRL, c);
      P.send(h, 1'b1);
      @(posedge CLK);
      chk({30'h0, hv, hit}, {30'h0, 1'b1, e});
   endtask
   initial begin
      b = '{valid: 1'b1, proto: PROTO_TCP, ttl: 8'h40, more_frag: 1'b0, frag_ofs: 13'h0,
            options: 1'b0, src_adr: 32'h0a00_0001, dst_adr: 32'hc0a8_0105};
      h = b;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      rd(OFS_CTRL, CTRL_RST);
      rd(OFS_SRC_MSK, MSK_RST);
      rd(5'h1c, 32'h0);
      wr(OFS_CTRL, 32'hffff_ffff);
      rd(OFS_CTRL, 32'h000f_3f73);
      ev(32'h0, 1'b0);
      ev(32'h1, 1'b0);
      ev(32'h2, 1'b0);
      ev(IP, 1'b1);
      wr(OFS_PROTO, 32'hff);
      foreach (pt[i]) begin
         h.proto = pt[i][7:0];
         ev(IP | {25'h0, pt[i][11:9], 4'h0}, pt[i][8]);
      end
      h = b;
      ev(IP | 32'h100, 1'b0);
      ev(IP | 32'h200, 1'b1);
      h.ttl = 8'h00;
      ev(IP | 32'h100, 1'b1);
      h = b;
      h.more_frag = 1'b1;
      ev(IP | 32'h400, 1'b0);
      h = b;
      h.frag_ofs = 13'h1fff;
      ev(IP | 32'h400, 1'b0);
      ev(IP | 32'h800, 1'b1);
      h.options = 1'b1;
      ev(IP | 32'h1000, 1'b0);
      ev(IP | 32'h2000, 1'b1);
      h.more_frag = 1'b1;
      h.ttl = 8'hff;
      ev(IP, 1'b1);
      wr(OFS_SRC_ADR, 32'h0a00_0001);
      wr(OFS_SRC_MSK, 32'hffff_fffe);
      wr(OFS_DST_ADR, 32'hc0a8_0105);
      wr(OFS_DST_MSK, 32'h7fff_ffff);
      h = b;
      h.src_adr[0] = 1'b0;
      ev(IP | 32'h1_0000, 1'b0);
      ev(IP | 32'h2_0000, 1'b1);
      h.src_adr[31] = 1'b1;
      ev(IP | 32'h2_0000, 1'b0);
      ev(IP, 1'b1);
      h = b;
      h.dst_adr[0] = 1'b0;
      ev(IP | 32'h4_0000, 1'b0);
      ev(IP | 32'h8_0000, 1'b0);
      ev(IP, 1'b1);
      h.dst_adr = b.dst_adr ^ 32'h8000_0000;
      ev(IP | 32'h8_0000, 1'b1);
      wr(OFS_STATUS, 32'h0);
      wr(OFS_CTRL, IP | 32'h1_0100);
      h = b;
      h.ttl = 8'h00;
      P.send(h, 1'b0);
      h.src_adr = 32'h0;
      P.send(h, 1'b1);
      chk({30'h0, hv, hit}, 32'h3);
      @(posedge CLK);
      chk({30'h0, hv, hit}, 32'h2);
      rd(OFS_STATUS, 32'h0000_0001);
      report_and_stop();
   end
endmodule
bind ipv4_acl_entry_matcher acl_entry_checker u_chk (.CLK(CLK), .RST(RST), .AVL_REQ(AVL_REQ),
   .AVL_WAITREQUEST(AVL_WAITREQUEST), .AVL_READDATA(AVL_READDATA), .HDR(HDR),
   .HIT_VALID(HIT_VALID), .HIT(HIT));
